// file: rtl/pos_steering.sv
// Contract
// - single mode, B enable puts PWM on pin B, else inactive level
// - complementary mode, B enable puts complementary PWM on pin B
// - single or complementary mode, A enable routes PWM to pin A
// - 3-phase, A bit drives A and D high, others low
// - 3-phase, B bit drives A and F high, others low
// - 3-phase, a cleared steering bit activates no combination
// - 3-phase with several bits set, the lowest bit wins
// - sync bit 7 defers steering changes to period boundary
// - 3-phase low-side enable bit 1 modulates pins B, D, F
// - modulated low side follows modulation when high, low when low
// - low-side enable clear, B D F follow steering directly
// - high-side enable bit 0 modulates A C E likewise
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pos_steering
  import pos_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pwm sources
  input  wire logic        pwmRaw,
  input  wire logic        pwmCompl,
  input  wire logic        modulationSource,
  input  wire logic        periodBoundary,
  // output pins
  output logic             pwmPinA,
  output logic             pwmPinB,
  output logic             pwmPinC,
  output logic             pwmPinD,
  output logic             pwmPinE,
  output logic             pwmPinF
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] outputSteeringSelect;
  logic [7:0] steeringSyncModulationCtrl;
  logic [3:0] outputModeSelect;
  logic [7:0] activeSteer;
  logic       apbSetup;
  logic       wrEn;
  logic       hit;
  logic [5:0] next_pins;

  assign apbSetup = psel && !penable;
  assign wrEn     = psel && penable && pready && pwrite;
  assign hit      = (paddr == ADDR_STEER_SEL) || (paddr == ADDR_SYNC_MOD)
                    || (paddr == ADDR_MODE);

  // no wait state: ready in the first access cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= apbSetup;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      pslverr <= !hit;
      case (paddr)
        ADDR_STEER_SEL: prdata <= {24'h000000, outputSteeringSelect};
        ADDR_SYNC_MOD:  prdata <= {24'h000000, steeringSyncModulationCtrl};
        ADDR_MODE:      prdata <= {28'h0000000, outputModeSelect};
        default:        prdata <= 32'h0000_0000;
      endcase
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outputSteeringSelect       <= RST_STEER_SEL;
      steeringSyncModulationCtrl <= RST_SYNC_MOD;
      outputModeSelect           <= RST_MODE;
    end else if (wrEn) begin
      if (paddr == ADDR_STEER_SEL) begin
        outputSteeringSelect <= pwdata[7:0] & STEER_MASK;
      end
      if (paddr == ADDR_SYNC_MOD) begin
        steeringSyncModulationCtrl <= pwdata[7:0] & SYNC_MOD_MASK;
      end
      if (paddr == ADDR_MODE) begin
        outputModeSelect <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // steering update timing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      activeSteer <= RST_STEER_SEL;
    end else if (!steeringSyncModulationCtrl[BIT_PER_SYNC]
                 || periodBoundary) begin
      activeSteer <= outputSteeringSelect;
    end
  end

  // ----------------------------------------------------------------
  // pin selection
  // ----------------------------------------------------------------
  logic [5:0] combo;
  logic [5:0] modMask;
  logic       lsMod;
  logic       hsMod;

  assign lsMod = steeringSyncModulationCtrl[BIT_LS_MOD];
  assign hsMod = steeringSyncModulationCtrl[BIT_HS_MOD];

  always_comb begin
    // lowest set bit wins
    if (activeSteer[BIT_STEER_A])      combo = COMBO_A;
    else if (activeSteer[BIT_STEER_B]) combo = COMBO_B;
    else if (activeSteer[BIT_STEER_C]) combo = COMBO_C;
    else if (activeSteer[BIT_STEER_D]) combo = COMBO_D;
    else if (activeSteer[BIT_STEER_E]) combo = COMBO_E;
    else if (activeSteer[BIT_STEER_F]) combo = COMBO_F;
    else                               combo = 6'b000000;
  end

  always_comb begin
    modMask = 6'b000000;
    if (hsMod) modMask = modMask | HIGH_SIDES;
    if (lsMod) modMask = modMask | ~HIGH_SIDES;
  end

  always_comb begin
    next_pins = 6'b000000;
    case (outputModeSelect)
      POS_SINGLE: begin
        next_pins = activeSteer[5:0] & {6{pwmRaw}};
      end
      POS_COMPL: begin
        next_pins = activeSteer[5:0] & {6{pwmRaw}};
        next_pins[BIT_STEER_B] = activeSteer[BIT_STEER_B] && pwmCompl;
        next_pins[BIT_STEER_D] = activeSteer[BIT_STEER_D] && pwmCompl;
        next_pins[BIT_STEER_F] = activeSteer[BIT_STEER_F] && pwmCompl;
      end
      POS_THREE: begin
        // high levels on sides with modulation enabled gated by modulation, low stay low
        next_pins = combo & (~modMask | {6{modulationSource}});
      end
      default: begin
        next_pins = 6'b000000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {pwmPinF, pwmPinE, pwmPinD, pwmPinC, pwmPinB, pwmPinA} <= 6'b000000;
    end else begin
      {pwmPinF, pwmPinE, pwmPinD, pwmPinC, pwmPinB, pwmPinA} <= next_pins;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_three_phase_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_THREE && activeSteer[0] && !hsMod && !lsMod)
    |=> {pwmPinF, pwmPinE, pwmPinD, pwmPinC, pwmPinB, pwmPinA} == COMBO_A)
    else $error("3-phase A combination wrong");
  a_three_phase_b: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_THREE && activeSteer[1:0] == 2'b10
     && !hsMod && !lsMod)
    |=> {pwmPinF, pwmPinE, pwmPinD, pwmPinC, pwmPinB, pwmPinA} == COMBO_B)
    else $error("3-phase B combination wrong");
  a_none_active: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_THREE && activeSteer[5:0] == 6'b000000)
    |=> {pwmPinF, pwmPinE, pwmPinD, pwmPinC, pwmPinB, pwmPinA} == 6'b000000)
    else $error("cleared steering drove a pin");
  a_single_b: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_SINGLE) |=> pwmPinB == $past(
      activeSteer[1] && pwmRaw))
    else $error("single mode pin b wrong");
  a_compl_b: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_COMPL) |=> pwmPinB == $past(
      activeSteer[1] && pwmCompl))
    else $error("complementary pin b wrong");
  a_single_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect[3:1] == 3'b000) |=> pwmPinA == $past(
      activeSteer[0] && pwmRaw))
    else $error("pin a steering wrong");
  a_sync_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (steeringSyncModulationCtrl[7] && !periodBoundary)
    |=> $stable(activeSteer))
    else $error("steering changed off boundary");
  a_low_mod: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_THREE && lsMod && activeSteer[0]
     && !modulationSource) |=> !pwmPinD)
    else $error("low side not modulated");
  a_high_mod: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_THREE && !hsMod && activeSteer[0])
    |=> pwmPinA)
    else $error("high side modulated while off");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    steeringSyncModulationCtrl[6:2] == 5'b00000)
    else $error("reserved bits set");

  // ----------------------------------------------------------------
  // register access checks
  // ----------------------------------------------------------------
  logic [5:0] pinsNow;
  logic       isThree;
  assign pinsNow = {pwmPinF, pwmPinE, pwmPinD, pwmPinC, pwmPinB, pwmPinA};
  assign isThree = (outputModeSelect == POS_THREE);

  a_ready_after_setup: assert property (@(posedge clk_sys) disable iff (!rst_b)
    apbSetup
    |=> pready)
    else $error("ready missing after setup");
  a_ready_needs_setup: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !apbSetup
    |=> !pready)
    else $error("ready without setup");
  a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbSetup && !hit)
    |=> pslverr)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbSetup && hit)
    |=> !pslverr)
    else $error("mapped access flagged");
  a_read_steer: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbSetup && paddr == ADDR_STEER_SEL)
    |=> prdata == {24'h000000, $past(outputSteeringSelect)})
    else $error("steering read wrong");
  a_read_sync: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbSetup && paddr == ADDR_SYNC_MOD)
    |=> prdata == {24'h000000, $past(steeringSyncModulationCtrl)})
    else $error("sync register read wrong");
  a_read_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbSetup && paddr == ADDR_MODE)
    |=> prdata == {28'h0000000, $past(outputModeSelect)})
    else $error("mode read wrong");
  a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (apbSetup && !hit)
    |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_write_steer: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wrEn && paddr == ADDR_STEER_SEL)
    |=> outputSteeringSelect == ($past(pwdata[7:0]) & STEER_MASK))
    else $error("steering write lost");
  a_write_sync: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wrEn && paddr == ADDR_SYNC_MOD)
    |=> steeringSyncModulationCtrl == ($past(pwdata[7:0]) & SYNC_MOD_MASK))
    else $error("sync write lost");
  a_write_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wrEn && paddr == ADDR_MODE)
    |=> outputModeSelect == $past(pwdata[3:0]))
    else $error("mode write lost");
  a_no_write_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wrEn
    |=> $stable(outputSteeringSelect) && $stable(outputModeSelect))
    else $error("register changed without write");
  a_sync_no_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wrEn
    |=> $stable(steeringSyncModulationCtrl))
    else $error("sync register changed without write");
  a_steer_top_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    outputSteeringSelect[7:6]
    == 2'b00)
    else $error("steering top bits set");

  // ----------------------------------------------------------------
  // steering and pin checks
  // ----------------------------------------------------------------
  a_sync_off_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !steeringSyncModulationCtrl[BIT_PER_SYNC]
    |=> activeSteer == $past(outputSteeringSelect))
    else $error("steering not immediate");
  a_sync_boundary: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (steeringSyncModulationCtrl[BIT_PER_SYNC] && periodBoundary)
    |=> activeSteer == $past(outputSteeringSelect))
    else $error("steering not taken at boundary");
  a_single_d: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_SINGLE)
    |=> pwmPinD == $past(activeSteer[BIT_STEER_D] && pwmRaw))
    else $error("single mode pin d wrong");
  a_compl_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_COMPL)
    |=> pwmPinA == $past(activeSteer[BIT_STEER_A] && pwmRaw))
    else $error("complementary pin a wrong");
  a_single_b_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_SINGLE && !activeSteer[BIT_STEER_B])
    |=> !pwmPinB)
    else $error("single pin b active while off");
  a_compl_b_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_COMPL && !activeSteer[BIT_STEER_B])
    |=> !pwmPinB)
    else $error("complementary pin b active while off");
  a_low_mod_pass: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && lsMod && !hsMod && activeSteer[BIT_STEER_A] && modulationSource)
    |=> pinsNow == COMBO_A)
    else $error("low side modulation blocked");
  a_low_side_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && lsMod && activeSteer[BIT_STEER_A])
    |=> !pwmPinB && !pwmPinC && !pwmPinE && !pwmPinF)
    else $error("low level pin driven");
  a_high_mod_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && hsMod && activeSteer[BIT_STEER_A] && !modulationSource)
    |=> !pwmPinA)
    else $error("high side not modulated");
  a_high_mod_pass: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && hsMod && activeSteer[BIT_STEER_A] && modulationSource)
    |=> pwmPinA)
    else $error("high side modulation blocked");
  a_low_unmod: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && !lsMod && activeSteer[BIT_STEER_A])
    |=> pwmPinD)
    else $error("low side modulated while off");
  a_a_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && activeSteer[BIT_STEER_A] && !hsMod && !lsMod)
    |=> pinsNow == COMBO_A)
    else $error("lowest steering bit lost");
  a_three_b_mod: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && activeSteer[1:0] == 2'b10 && hsMod && lsMod
     && !modulationSource)
    |=> pinsNow == 6'b000000)
    else $error("both sides not modulated");
  a_single_no_mod: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_SINGLE)
    |=> pinsNow == $past(activeSteer[5:0] & {6{pwmRaw}}))
    else $error("single mode pins wrong");
  a_compl_no_mod: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect == POS_COMPL)
    |=> pinsNow == $past(activeSteer[5:0] & {3{pwmCompl, pwmRaw}}))
    else $error("complementary pins wrong");
  a_other_mode_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (outputModeSelect != POS_SINGLE && outputModeSelect != POS_COMPL
     && !isThree)
    |=> pinsNow == 6'b000000)
    else $error("undefined mode drove a pin");
  a_three_pair: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (isThree && !hsMod && !lsMod && activeSteer[5:0] != 6'b000000)
    |=> $countones(pinsNow) == 2)
    else $error("3-phase combination not a pair");
endmodule // pos_steering

// file: rtl/pos_pkg.sv
package pos_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_STEER_SEL  = 12'h000;
  localparam logic [11:0] ADDR_SYNC_MOD   = 12'h004;
  localparam logic [11:0] ADDR_MODE       = 12'h008;
  localparam logic [7:0]  RST_STEER_SEL   = 8'h00;
  localparam logic [7:0]  RST_SYNC_MOD    = 8'h00;
  localparam logic [3:0]  RST_MODE        = 4'h0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_STEER_A   = 0;
  localparam int BIT_STEER_B   = 1;
  localparam int BIT_STEER_C   = 2;
  localparam int BIT_STEER_D   = 3;
  localparam int BIT_STEER_E   = 4;
  localparam int BIT_STEER_F   = 5;
  localparam int BIT_HS_MOD    = 0;
  localparam int BIT_LS_MOD    = 1;
  localparam int BIT_PER_SYNC  = 7;
  localparam logic [7:0] SYNC_MOD_MASK = 8'h83;
  localparam logic [7:0] STEER_MASK    = 8'h3f;
  // ----------------------------------------------------------------
  // modes and pin combinations (pin order f e d c b a)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    POS_SINGLE = 4'b0000,
    POS_COMPL  = 4'b0001,
    POS_THREE  = 4'b1100
  } pos_mode_t;
  localparam logic [5:0] COMBO_A    = 6'b001001;
  localparam logic [5:0] COMBO_B    = 6'b100001;
  localparam logic [5:0] COMBO_C    = 6'b100100;
  localparam logic [5:0] COMBO_D    = 6'b000110;
  localparam logic [5:0] COMBO_E    = 6'b010010;
  localparam logic [5:0] COMBO_F    = 6'b011000;
  localparam logic [5:0] HIGH_SIDES = 6'b010101;
endpackage

// file: tb/pos_gate_drv.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// gate driver model: one switch per pin, on while pin high
// ----------------------------------------------------------------
module pos_gate_drv (
  // pin levels
  input  wire logic       pinA,
  input  wire logic       pinB,
  input  wire logic       pinC,
  input  wire logic       pinD,
  input  wire logic       pinE,
  input  wire logic       pinF,
  // switch states, order f e d c b a
  output logic      [5:0] gateOn
);
  assign gateOn = {pinF, pinE, pinD, pinC, pinB, pinA};
endmodule // pos_gate_drv

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import pos_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, periodBoundary = 0;
  logic        pwmRaw = 0, pwmCompl = 0, modulationSource = 0;
  logic        pwmPinA, pwmPinB, pwmPinC, pwmPinD, pwmPinE, pwmPinF;
  logic [5:0]  gateOn, act;
  logic [3:0]  mode;
  logic [7:0]  ctrl;
  int          fails = 0, tests_run = 0;
  localparam logic [5:0] CMB [6] = '{COMBO_A, COMBO_B, COMBO_C,
                                     COMBO_D, COMBO_E, COMBO_F};
  always #25 clk_sys = ~clk_sys;
  pos_steering u_dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .pwmRaw, .pwmCompl,
    .modulationSource, .periodBoundary, .pwmPinA, .pwmPinB, .pwmPinC,
    .pwmPinD, .pwmPinE, .pwmPinF);
  pos_gate_drv u_drv (.pinA(pwmPinA), .pinB(pwmPinB), .pinC(pwmPinC),
    .pinD(pwmPinD), .pinE(pwmPinE), .pinF(pwmPinF), .gateOn(gateOn));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdchk(logic [11:0] a, logic [31:0] exp, logic e);
    apb(0, a, 0);
    chk("prdata", exp, rd);
    chk("pslverr", e, err);
  endtask
  function automatic logic [5:0] exp_pins();
    logic [5:0] c;
    c = 6'h00;
    case (mode)
      4'b0000: c = act & {6{pwmRaw}};
      4'b0001: c = act & {3{pwmCompl, pwmRaw}};
      4'b1100: begin
        for (int i = 5; i >= 0; i--) if (act[i]) c = CMB[i];
        if (ctrl[0]) c = c & (~HIGH_SIDES | {6{modulationSource}});
        if (ctrl[1]) c = c & (HIGH_SIDES | {6{modulationSource}});
      end
      default: c = 6'h00;
    endcase
    return c;
  endfunction
  task automatic chkp();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pins", {26'h0, exp_pins()}, {26'h0, gateOn});
  endtask
  task automatic steer(logic [3:0] m, logic [7:0] s, logic [7:0] c);
    apb(1, ADDR_MODE, {28'h0, m});
    apb(1, ADDR_SYNC_MOD, {24'h0, c});
    apb(1, ADDR_STEER_SEL, {24'h0, s});
    mode = m; ctrl = c; act = s[5:0];
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      {modulationSource, pwmCompl, pwmRaw} <= k[2:0];
      chkp();
    end
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1;
    rdchk(ADDR_STEER_SEL, 32'h0, 0);
    rdchk(ADDR_SYNC_MOD, 32'h0, 0);
    rdchk(ADDR_MODE, 32'h0, 0);
    apb(1, ADDR_SYNC_MOD, 32'hff);
    rdchk(ADDR_SYNC_MOD, 32'h83, 0);
    rdchk(12'h00c, 32'h0, 1);
    steer(4'b0010, 8'h03, 8'h03);
    steer(4'b0000, 8'h02, 8'h03);
    steer(4'b0000, 8'h01, 8'h00);
    steer(4'b0001, 8'h03, 8'h03);
    steer(4'b0001, 8'h00, 8'h00);
    steer(4'b1100, 8'h01, 8'h00);
    steer(4'b1100, 8'h02, 8'h00);
    steer(4'b1100, 8'h00, 8'h00);
    steer(4'b1100, 8'h06, 8'h00);
    steer(4'b1100, 8'h3f, 8'h03);
    steer(4'b1100, 8'h01, 8'h02);
    steer(4'b1100, 8'h02, 8'h01);
    apb(1, ADDR_SYNC_MOD, 32'h80);
    ctrl = 8'h80;
    apb(1, ADDR_STEER_SEL, 32'h01);
    chkp();
    @(posedge clk_sys);
    periodBoundary <= 1;
    @(posedge clk_sys);
    periodBoundary <= 0;
    act = 6'h01;
    chkp();
    end_sim();
  end
endmodule // tb
